// File: rtl/pump_link_pkg.sv
// Purpose: shared constants and helpers for the pump serial framer
// Assumes: byte stream from a uart on the same clock
// Notes: all register offsets are byte addresses on a 32-bit bus
package pump_link_pkg;
  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam logic [7:0] HDR0 = 8'h4d;
  localparam logic [7:0] HDR1 = 8'h4a;
  localparam logic [7:0] TERM = 8'h0d;
  localparam logic [15:0] ID_DEFAULT = 16'h3031;
  localparam logic [15:0] ID_CONFIG = 16'h3939;
  localparam logic [5:0] ID_MAX = 6'd32;
  localparam int SUB_MAX = 16;
  localparam int BODY_MAX = SUB_MAX + 4;
  localparam logic [4:0] FIXED_LEN = 5'd4;
  // ---------------------------------------------------------------
  // command and answer codes
  // ---------------------------------------------------------------
  localparam logic [15:0] CMD_CLAIM = 16'h4c4e;
  localparam logic [15:0] CMD_RELEASE = 16'h4c46;
  localparam logic [15:0] CMD_MODE_QUERY = 16'h4c53;
  localparam logic [15:0] CMD_START = 16'h5254;
  localparam logic [15:0] CMD_STOP = 16'h5250;
  localparam logic [15:0] CMD_RESET = 16'h5252;
  localparam logic [15:0] ANS_LOCAL = 16'h4c4c;
  localparam logic [15:0] ANS_REMOTE = 16'h4c52;
  localparam logic [15:0] ANS_SERIAL = 16'h4c44;
  localparam logic [15:0] ANS_INVALID = 16'h5256;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RXCMD = 8'h08;
  localparam logic [7:0] REG_TXCMD = 8'h0c;
  localparam logic [7:0] REG_RXDATA = 8'h10;
  localparam logic [7:0] REG_TXDATA = 8'h20;
  localparam int CTRL_MULTI = 0;
  localparam int CTRL_REMOTE = 1;
  localparam int CTRL_ID_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0100;
  localparam int TX_ANSWER_GO = 31;
  localparam int TX_EVENT_GO = 30;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int ANSWER_TIMEOUT_MS = 1000;
  localparam int ANSWER_TIMEOUT_CYC = ANSWER_TIMEOUT_MS * CLK_MHZ * 1000;

  typedef enum logic [1:0] {MODE_LOCAL, MODE_REMOTE, MODE_SERIAL} mode_e;

  function automatic logic [7:0] hexChar(input logic [3:0] n);
    hexChar = (n < 4'd10) ? 8'h30 + {4'h0, n} : 8'h57 + {4'h0, n};
  endfunction

  // bit 4 flags a character that is no hex digit; either case accepted
  function automatic logic [4:0] hexVal(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) hexVal = {1'b0, c[3:0]};
    else if ((c | 8'h20) >= 8'h61 && (c | 8'h20) <= 8'h66)
      hexVal = {1'b0, c[3:0] + 4'd9};
    else hexVal = 5'h10;
  endfunction

  function automatic logic [15:0] decId(input logic [5:0] n);
    logic [5:0] tens;
    tens = (n >= 6'd30) ? 6'd3 : (n >= 6'd20) ? 6'd2 :
           (n >= 6'd10) ? 6'd1 : 6'd0;
    decId = {8'h30 + {5'h0, tens[2:0]},
             8'h30 + {4'h0, 4'(n - 6'(tens * 6'd10))}};
  endfunction
endpackage

// File: rtl/frame_receiver.sv
// Purpose: hunts frame headers and collects one command frame
// Assumes: one byte per rxValid pulse
// Notes: the checksum test runs when the terminator arrives
`timescale 1ns/1ps
module frame_receiver (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] rxByte,
  input wire logic rxValid,
  output logic frameDone,
  output logic cksOk,
  output logic [15:0] frameId,
  output logic [15:0] frameCode,
  output logic [8*pump_link_pkg::SUB_MAX-1:0] frameSub,
  output logic [4:0] subLen
);
  import pump_link_pkg::*;
  typedef enum {HUNT, HDR, ID0, ID1, BODY} rx_e;
  rx_e state;
  logic [7:0] body [BODY_MAX];
  logic [4:0] cnt;
  logic [7:0] sum, p1, p2;
  logic ovf;
  logic [4:0] hiV, loV;

  assign hiV = hexVal(p2);
  assign loV = hexVal(p1);

  always_ff @(posedge clk) begin
    frameDone <= 1'b0;
    if (rst) begin
      state <= HUNT;
      cnt <= 5'd0;
      sum <= 8'h00;
      p1 <= 8'h00;
      p2 <= 8'h00;
      ovf <= 1'b0;
      cksOk <= 1'b0;
      frameId <= 16'h0000;
      frameCode <= 16'h0000;
      frameSub <= '0;
      subLen <= 5'd0;
    end else if (rxValid) begin
      case (state)
        HUNT: if (rxByte == HDR0) state <= HDR;
        HDR: begin
          if (rxByte == HDR1) state <= ID0;
          else if (rxByte != HDR0) state <= HUNT;
          sum <= HDR0 + HDR1;
        end
        ID0: begin
          frameId[15:8] <= rxByte;
          sum <= sum + rxByte;
          state <= ID1;
        end
        ID1: begin
          frameId[7:0] <= rxByte;
          sum <= sum + rxByte;
          cnt <= 5'd0;
          ovf <= 1'b0;
          state <= BODY;
        end
        BODY: begin
          if (rxByte == TERM) begin
            // short or overlong frames vanish without a trace
            frameDone <= (cnt >= FIXED_LEN) && !ovf;
            cksOk <= !hiV[4] && !loV[4] &&
                     (sum - p1 - p2) == {hiV[3:0], loV[3:0]};
            frameCode <= {body[0], body[1]};
            for (int i = 0; i < SUB_MAX; i++)
              frameSub[8*i +: 8] <= body[i+2];
            subLen <= cnt - FIXED_LEN;
            state <= HUNT;
          end else begin
            if (cnt == 5'(BODY_MAX)) ovf <= 1'b1;
            else cnt <= cnt + 5'd1;
            sum <= sum + rxByte;
            p2 <= p1;
            p1 <= rxByte;
          end
        end
        default: state <= HUNT;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (state == BODY && rxValid && rxByte != TERM &&
        cnt < 5'(BODY_MAX))
      body[cnt] <= rxByte;
  end
endmodule

// File: rtl/frame_sender.sv
// Purpose: serialises one frame with header, checksum and terminator
// Assumes: sink takes bytes by txValid and txReady
// Notes: checksum accumulates as bytes leave
`timescale 1ns/1ps
module frame_sender (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [15:0] id,
  input wire logic [15:0] code,
  input wire logic [8*pump_link_pkg::SUB_MAX-1:0] sub,
  input wire logic [4:0] len,
  output logic [7:0] txByte,
  output logic txValid,
  input wire logic txReady,
  output logic busy,
  output logic done
);
  import pump_link_pkg::*;
  logic [15:0] idQ, codeQ;
  logic [8*SUB_MAX-1:0] subQ;
  logic [4:0] lenQ, idx;
  logic [7:0] sum, next_sum;
  logic [5:0] last;

  function automatic logic [7:0] byteAt(input logic [4:0] k,
                                        input logic [7:0] s);
    if (k == 5'd1) byteAt = HDR1;
    else if (k == 5'd2) byteAt = idQ[15:8];
    else if (k == 5'd3) byteAt = idQ[7:0];
    else if (k == 5'd4) byteAt = codeQ[15:8];
    else if (k == 5'd5) byteAt = codeQ[7:0];
    else if (k < lenQ + 5'd6) byteAt = subQ[8*(k-5'd6) +: 8];
    else if (k == lenQ + 5'd6) byteAt = hexChar(s[7:4]);
    else if (k == lenQ + 5'd7) byteAt = hexChar(s[3:0]);
    else byteAt = TERM;
  endfunction

  assign txValid = busy;
  assign last = {1'b0, lenQ} + 6'd8;
  assign next_sum = (idx < lenQ + 5'd6) ? sum + txByte : sum;

  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      busy <= 1'b0;
      idx <= 5'd0;
      sum <= 8'h00;
      txByte <= 8'h00;
      idQ <= 16'h0000;
      codeQ <= 16'h0000;
      subQ <= '0;
      lenQ <= 5'd0;
    end else if (!busy) begin
      if (start) begin
        busy <= 1'b1;
        idx <= 5'd0;
        sum <= 8'h00;
        txByte <= HDR0;
        idQ <= id;
        codeQ <= code;
        subQ <= sub;
        lenQ <= (len > 5'(SUB_MAX)) ? 5'(SUB_MAX) : len;
      end
    end else if (txReady) begin
      if ({1'b0, idx} == last) begin
        busy <= 1'b0;
        done <= 1'b1;
      end else begin
        idx <= idx + 5'd1;
        sum <= next_sum;
        txByte <= byteAt(idx + 5'd1, next_sum);
      end
    end
  end
endmodule

// File: rtl/pump_serial_message_framer.sv
// Purpose: command and answer framing for the pump serial link
// Assumes: uart bytes on clk; axi4-lite register access
// Notes: control commands reach software only in serial mode
// What this block does
// - frames start with 4d 4a and end with 0d.
// - header, id, command, sub-command, checksum, terminator in order.
// - with multi-drop off the network id is 01.
// - with multi-drop on the id is decimal 01 to 32.
// - link configuration frames use id 99.
// - multi-drop on checks the id and suppresses event messages.
// - new commands discarded while an answer is pending.
// - after the answer timeout new commands are accepted again.
// - normal answers begin within 100 ms of the command; software answers may start up to the 1000 ms timeout.
// - checksum is low byte of sum from header to sub-command.
// - host sends the claim command before control commands.
// - start, stop, reset accepted only in serial mode.
// - serial mode may be entered only from remote mode.
// - claim, release and mode query answered with the mode.
`timescale 1ns/1ps
module pump_serial_message_framer #(
  parameter int TIMEOUT_CYC = pump_link_pkg::ANSWER_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] rxByte,
  input wire logic rxValid,
  output logic [7:0] txByte,
  output logic txValid,
  input wire logic txReady,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import pump_link_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic frameDone, cksOk;
  logic [15:0] frameId, frameCode;
  logic [8*SUB_MAX-1:0] frameSub, txData, rxData, sendSub;
  logic [4:0] frameLen, rxLen, txLen, sendLen;
  logic [31:0] ctrl;
  logic [15:0] rxCode, txCode, ownId, ansId, autoCode;
  logic [15:0] sendId, sendCode;
  logic serialOn, pending, cmdAvail, idOk, accept, isAuto;
  logic autoReq, swReq, evReq, sendStart, txBusy, txDone;
  logic [1:0] sendKind, activeKind;
  logic [27:0] waitCnt;
  logic [7:0] dropCnt;
  logic awHeld, wHeld, doWrite;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic [31:0] next_rdata;
  logic next_rerr;
  mode_e mode;

  localparam logic [1:0] KIND_AUTO = 2'd0;
  localparam logic [1:0] KIND_SW = 2'd1;
  localparam logic [1:0] KIND_EVENT = 2'd2;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
  endfunction

  // ---------------------------------------------------------------
  // framing engines
  // ---------------------------------------------------------------
  frame_receiver u_rx (
    .clk(clk),
    .rst(rst),
    .rxByte(rxByte),
    .rxValid(rxValid),
    .frameDone(frameDone),
    .cksOk(cksOk),
    .frameId(frameId),
    .frameCode(frameCode),
    .frameSub(frameSub),
    .subLen(frameLen)
  );

  frame_sender u_tx (
    .clk(clk),
    .rst(rst),
    .start(sendStart),
    .id(sendId),
    .code(sendCode),
    .sub(sendSub),
    .len(sendLen),
    .txByte(txByte),
    .txValid(txValid),
    .txReady(txReady),
    .busy(txBusy),
    .done(txDone)
  );

  // ---------------------------------------------------------------
  // addressing and mode
  // ---------------------------------------------------------------
  always_comb begin
    ownId = ID_DEFAULT;
    if (ctrl[CTRL_MULTI] && ctrl[CTRL_ID_LSB +: 6] != 6'd0 &&
        ctrl[CTRL_ID_LSB +: 6] <= ID_MAX)
      ownId = decId(ctrl[CTRL_ID_LSB +: 6]);
  end

  assign idOk = (frameId == ownId) || (frameId == ID_CONFIG);
  assign accept = frameDone && cksOk && idOk && !pending;

  // serial mode drops back to local when the remote switch opens
  assign mode = !ctrl[CTRL_REMOTE] ? MODE_LOCAL :
                serialOn ? MODE_SERIAL : MODE_REMOTE;

  always_ff @(posedge clk) begin
    if (rst) serialOn <= 1'b0;
    else if (!ctrl[CTRL_REMOTE]) serialOn <= 1'b0;
    else if (accept && frameCode == CMD_CLAIM) serialOn <= 1'b1;
    else if (accept && frameCode == CMD_RELEASE) serialOn <= 1'b0;
  end

  // ---------------------------------------------------------------
  // command dispatch
  // ---------------------------------------------------------------
  always_comb begin
    isAuto = 1'b1;
    autoCode = ANS_INVALID;
    case (frameCode)
      CMD_CLAIM: autoCode = ctrl[CTRL_REMOTE] ? ANS_SERIAL : ANS_LOCAL;
      CMD_RELEASE: autoCode = ctrl[CTRL_REMOTE] ? ANS_REMOTE : ANS_LOCAL;
      CMD_MODE_QUERY: begin
        autoCode = (mode == MODE_SERIAL) ? ANS_SERIAL :
                   (mode == MODE_REMOTE) ? ANS_REMOTE : ANS_LOCAL;
      end
      CMD_START, CMD_STOP, CMD_RESET: begin
        isAuto = mode != MODE_SERIAL;
      end
      default: isAuto = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pending <= 1'b0;
      waitCnt <= 28'd0;
      ansId <= ID_DEFAULT;
      autoReq <= 1'b0;
      rxCode <= 16'h0000;
      rxData <= '0;
      rxLen <= 5'd0;
    end else if (accept) begin
      pending <= 1'b1;
      waitCnt <= 28'd0;
      ansId <= frameId;
      autoReq <= isAuto;
      if (!isAuto) begin
        rxCode <= frameCode;
        rxData <= frameSub;
        rxLen <= frameLen;
      end
    end else begin
      if (sendStart && sendKind == KIND_AUTO) autoReq <= 1'b0;
      if (txDone && activeKind != KIND_EVENT) pending <= 1'b0;
      else if (pending && waitCnt == 28'(TIMEOUT_CYC - 1)) begin
        pending <= 1'b0;
        autoReq <= 1'b0;
      end else if (pending) waitCnt <= waitCnt + 28'd1;
    end
  end

  // set on accept wins over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) cmdAvail <= 1'b0;
    else if (accept && !isAuto) cmdAvail <= 1'b1;
    else if (doWrite && awAddr == REG_TXCMD && wStrb[3] &&
             wData[TX_ANSWER_GO]) cmdAvail <= 1'b0;
    else if (!pending) cmdAvail <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) dropCnt <= 8'h00;
    else if (frameDone && !accept) dropCnt <= dropCnt + 8'h01;
  end

  // ---------------------------------------------------------------
  // answer and event launch
  // ---------------------------------------------------------------
  assign sendKind = autoReq ? KIND_AUTO : swReq ? KIND_SW : KIND_EVENT;
  assign sendStart = !txBusy && (autoReq || swReq || evReq);
  assign sendId = (sendKind == KIND_EVENT) ? ownId : ansId;
  assign sendCode = (sendKind == KIND_AUTO) ? autoCode : txCode;
  assign sendSub = txData;
  assign sendLen = (sendKind == KIND_AUTO) ? 5'd0 : txLen;

  always_ff @(posedge clk) begin
    if (rst) activeKind <= KIND_AUTO;
    else if (sendStart) activeKind <= sendKind;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      swReq <= 1'b0;
      evReq <= 1'b0;
    end else begin
      if (doWrite && awAddr == REG_TXCMD && wStrb[3]) begin
        if (wData[TX_ANSWER_GO] && pending) swReq <= 1'b1;
        if (wData[TX_EVENT_GO] && !ctrl[CTRL_MULTI])
          evReq <= 1'b1;
      end else begin
        if (sendStart && sendKind == KIND_SW) swReq <= 1'b0;
        if (sendStart && sendKind == KIND_EVENT) evReq <= 1'b0;
        if (!pending) swReq <= 1'b0;
        if (ctrl[CTRL_MULTI]) evReq <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  assign s_axi_awready = !awHeld;
  assign s_axi_wready = !wHeld;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !awHeld) begin
        awHeld <= 1'b1;
        awAddr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !wHeld) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr <= REG_TXCMD ||
                        awAddr[7:4] == REG_TXDATA[7:4]) &&
                       awAddr != REG_STATUS && awAddr != REG_RXCMD ?
                       RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
      txCode <= 16'h0000;
      txLen <= 5'd0;
      txData <= '0;
    end else if (doWrite) begin
      if (awAddr == REG_CTRL) ctrl <= merge(ctrl, wData, wStrb);
      if (awAddr == REG_TXCMD) begin
        if (wStrb[0]) txCode[7:0] <= wData[7:0];
        if (wStrb[1]) txCode[15:8] <= wData[15:8];
        if (wStrb[2]) txLen <= wData[20:16];
      end
      if (awAddr[7:4] == REG_TXDATA[7:4])
        txData[32*awAddr[3:2] +: 32] <=
          merge(txData[32*awAddr[3:2] +: 32], wData, wStrb);
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rerr = 1'b0;
    if (s_axi_araddr[7:4] == REG_RXDATA[7:4])
      next_rdata = rxData[32*s_axi_araddr[3:2] +: 32];
    else if (s_axi_araddr[7:4] == REG_TXDATA[7:4])
      next_rdata = txData[32*s_axi_araddr[3:2] +: 32];
    else begin
      case ({s_axi_araddr[7:2], 2'b00})
        REG_CTRL: next_rdata = ctrl;
        REG_STATUS: next_rdata = {16'h0000, dropCnt, 2'b00, evReq,
                                  txBusy, cmdAvail, pending,
                                  2'(mode)};
        REG_RXCMD: next_rdata = {11'h000, rxLen, rxCode};
        REG_TXCMD: next_rdata = {11'h000, txLen, txCode};
        default: next_rerr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rerr ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end
endmodule

// File: dv/pump_framer_checker.sv
// Purpose: port checks for the pump serial framer
// Assumes: one clock, sync reset
// Notes: bound to the framer top
`timescale 1ns/1ps
module pump_framer_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] txByte,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import pump_link_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_tx_hold: assert property (
    txValid && !txReady |=> txValid && $stable(txByte))
    else $error("tx byte moved while stalled");
  a_frame_head: assert property (
    $rose(txValid) |-> txByte == HDR0)
    else $error("frame does not open with header");
  a_head_pair: assert property (
    $rose(txValid) && txReady |=> txByte == HDR1)
    else $error("second header byte wrong");
  a_frame_end: assert property (
    txValid && txReady && txByte == TERM |=> !txValid)
    else $error("sender still busy after terminator");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_r_retire: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not retired");
  a_rd_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
endmodule

bind pump_serial_message_framer pump_framer_checker u_chk (.clk(clk),
  .rst(rst), .txByte(txByte), .txValid(txValid), .txReady(txReady),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// File: dv/pump_host_model.sv
// Purpose: host side of the serial link
// Assumes: one byte per two clocks outbound
// Notes: slow stalls txReady three cycles in four
`timescale 1ns/1ps
module pump_host_model (
  input wire logic clk,
  input wire logic [7:0] txByte,
  input wire logic txValid,
  output logic txReady,
  output logic [7:0] rxByte,
  output logic rxValid,
  input wire logic slow
);
  logic [7:0] rxq[$];
  logic [7:0] s;
  logic [15:0] ansId, ansCode;
  logic ansOk;
  logic [1:0] tick = '0;
  int nAns = 0;
  int k;
  initial begin
    rxByte = 8'h00;
    rxValid = 1'b0;
    txReady = 1'b1;
  end
  function automatic logic [7:0] hx(input logic [3:0] n, input bit up);
    hx = (n < 4'd10) ? 8'h30 + {4'h0, n} : (up ? 8'h37 : 8'h57) + {4'h0, n};
  endfunction
  task automatic send(input logic [15:0] id, code, input bit bad);
    logic [7:0] f[$];
    logic [7:0] c;
    f = '{8'h4d, 8'h4a, id[15:8], id[7:0], code[15:8], code[7:0]};
    c = 8'h00;
    foreach (f[i]) c += f[i];
    c ^= {7'h0, bad};
    f.push_back(hx(c[7:4], 1'b1));
    f.push_back(hx(c[3:0], 1'b1));
    f.push_back(8'h0d);
    foreach (f[i]) begin
      @(posedge clk);
      rxByte <= f[i];
      rxValid <= 1'b1;
      @(posedge clk);
      rxValid <= 1'b0;
      rxByte <= ~f[i];
    end
  endtask
  always @(posedge clk) begin
    tick <= tick + 2'd1;
    txReady <= !slow || tick == 2'd0;
    if (txValid && txReady) begin
      rxq.push_back(txByte);
      if (txByte == 8'h0d) begin
        k = 0;
        while (k + 1 < rxq.size() && !(rxq[k] == 8'h4d && rxq[k+1] == 8'h4a))
          k++;
        s = 8'h00;
        for (int i = k; i < rxq.size() - 3; i++) s += rxq[i];
        ansId = {rxq[k+2], rxq[k+3]};
        ansCode = {rxq[k+4], rxq[k+5]};
        ansOk = rxq.size() - k == 9 && rxq[k+6] == hx(s[7:4], 1'b0)
          && rxq[k+7] == hx(s[3:0], 1'b0);
        nAns++;
        rxq.delete();
      end
    end
  end
endmodule

// File: dv/tb_top.sv
// Purpose: self-checking bench for the pump serial framer
// Assumes: short answer timeout for simulation
// Notes: host model drives the link side
`timescale 1ns/1ps
module tb_top;
  import pump_link_pkg::*;
  localparam int TO = 400;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  logic txReady, rxValid, txValid;
  logic [7:0] rxByte, txByte, s_axi_awaddr = '0, s_axi_araddr = '0, d0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, aw, w;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  int n_fail = 0, n_tests = 0, cyc = 0;
  always #2.5 clk = ~clk;
  pump_serial_message_framer #(.TIMEOUT_CYC(TO)) u_pump_serial_message_framer
    (.*);
  pump_host_model u_host (.*);
  task automatic end_sim;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_sim;
    end
  end
  task automatic check(input logic [31:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    {aw, w} = 2'b00;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axiRd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  // exp of zero means no answer may come back
  task automatic ask(input logic [15:0] id, code, exp, input bit snd, bad);
    int n0;
    n0 = u_host.nAns;
    if (snd) u_host.send(id, code, bad);
    for (int i = 0; i < 120 && u_host.nAns == n0; i++) @(posedge clk);
    check(32'(u_host.nAns - n0), exp != 0, "answer count");
    if (exp != 0) begin
      check(u_host.ansCode, exp, "answer code");
      check(u_host.ansId, id, "answer id");
      check(u_host.ansOk, 1, "answer checksum or length");
    end
  endtask
  task automatic t_regs;
    axiRd(REG_CTRL);
    check(rd, CTRL_RESET, "ctrl reset");
    axiRd(8'h40);
    check(rd, 0, "unmapped read data");
    check(resp, RESP_SLVERR, "unmapped read resp");
    axiWr(REG_STATUS, 32'h0000_00ff);
    check(resp, RESP_SLVERR, "status write");
    $display("test regs done");
  endtask
  task automatic t_modes;
    ask(ID_DEFAULT, CMD_START, ANS_INVALID, 1, 0);
    ask(ID_DEFAULT, CMD_CLAIM, ANS_LOCAL, 1, 0);
    axiWr(REG_CTRL, 32'h0000_0102);
    ask(ID_DEFAULT, CMD_MODE_QUERY, ANS_REMOTE, 1, 0);
    ask(ID_DEFAULT, CMD_RELEASE, ANS_REMOTE, 1, 0);
    ask(ID_DEFAULT, CMD_CLAIM, ANS_SERIAL, 1, 0);
    $display("test modes done");
  endtask
  task automatic t_pend;
    slow <= 1'b1;
    ask(ID_DEFAULT, CMD_START, 0, 1, 0);
    axiRd(REG_RXCMD);
    check(rd[15:0], CMD_START, "command to software");
    ask(ID_DEFAULT, CMD_MODE_QUERY, 0, 1, 0);
    axiWr(REG_TXCMD, 32'h8000_5241);
    ask(ID_DEFAULT, 0, 16'h5241, 0, 0);
    ask(ID_DEFAULT, CMD_STOP, 0, 1, 0);
    repeat (TO) @(posedge clk);
    ask(ID_DEFAULT, CMD_MODE_QUERY, ANS_SERIAL, 1, 0);
    slow <= 1'b0;
    $display("test pending done");
  endtask
  task automatic t_drop;
    axiRd(REG_STATUS);
    d0 = rd[15:8];
    ask(ID_DEFAULT, CMD_MODE_QUERY, 0, 1, 1);
    ask(16'h3035, CMD_MODE_QUERY, 0, 1, 0);
    axiRd(REG_STATUS);
    check(rd[15:8], d0 + 8'd2, "drop count");
    ask(ID_CONFIG, CMD_MODE_QUERY, ANS_SERIAL, 1, 0);
    $display("test drop done");
  endtask
  task automatic t_multi;
    axiWr(REG_CTRL, 32'h0000_2003);
    ask(16'h3332, CMD_MODE_QUERY, ANS_SERIAL, 1, 0);
    ask(ID_DEFAULT, CMD_MODE_QUERY, 0, 1, 0);
    axiWr(REG_TXCMD, 32'h4000_4e53);
    ask(ID_DEFAULT, 0, 0, 0, 0);
    axiWr(REG_CTRL, 32'h0000_0102);
    axiWr(REG_TXCMD, 32'h4000_4e53);
    ask(ID_DEFAULT, 0, 16'h4e53, 0, 0);
    $display("test multi done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_modes;
    t_pend;
    t_drop;
    t_multi;
    end_sim;
  end
endmodule
